// ### design/sic_params.svh
// Purpose: constants for the switch input channel control block
// Assumes: 125 MHz core clock, 24-bit serial frames
// Notes: command codes sit in frame bits 23:16
`ifndef SIC_PARAMS_SVH
`define SIC_PARAMS_SVH
`define SIC_NUM_IN 22
`define SIC_NUM_PROG 8
`define SIC_FRAME_BITS 24
`define SIC_CMD_HI 23
`define SIC_CMD_LO 16
`define SIC_CMD_SETTINGS 8'h01
`define SIC_CMD_METALLIC 8'h04
`define SIC_CMD_WETTING 8'h05
`define SIC_CMD_TRISTATE 8'h06
`define SIC_CMD_TRISTATE_SG 8'h07
`define SIC_CMD_ANALOG 8'h08
`define SIC_CMD_STATUS 8'h00
`define SIC_ANA_CH_HI 4
`define SIC_ANA_CUR_HI 6
`define SIC_ANA_CUR_LO 5
`define SIC_ANA_NONE 5'h1f
`define SIC_RST_TRI 22'h3fffff
`define SIC_RST_DIR 8'hff
`define SIC_RST_HI_LVL 22'h3fffff
`define SIC_RST_WET 22'h3fffff
`endif

// ### design/sic_pkg.sv
// Purpose: shared types for the switch input channel control block
// Assumes: constants come from sic_params.svh
// Notes: no imports, use sic_pkg::name
package sic_pkg;
  // analog current selection
  typedef enum logic [1:0] {
    SIC_ANA_HIZ = 2'b00,
    SIC_ANA_LO = 2'b01,
    SIC_ANA_HI = 2'b10
  } sic_ana_cur_t;
  // per-input drive request toward the analog pad ring
  typedef struct packed {
    logic [21:0] pullup_en;
    logic [21:0] pulldown_en;
    logic [21:0] high_level;
  } sic_drive_t;
  // analog multiplexer state
  typedef struct packed {
    logic valid;
    logic [4:0] channel;
    sic_ana_cur_t current;
  } sic_mux_t;
endpackage : sic_pkg

// ### design/sic_ctrl.sv
// Purpose: serial command decode, current source control, mux and status for 22 inputs
// Assumes: serial pins are asynchronous to core_clk_in and are sampled by it
// Notes: frame ends on rising chip select; commands act only at that edge
//
// Behaviour
// - decode channel code of analog-select command to pick one of 22 inputs.
// - mux connection changes only at chip select rising edge ending the frame.
// - analog-selected input reports zero in the next status frame.
// - analog input current choice: high impedance, 2.0 mA or 16 mA pull-up.
// - reset leaves normal mode with all current sources tri-stated.
// - programmable inputs can source or sink per switch direction.
// - battery-switch input, tri-state off, enables pull-down sink.
// - settings command loads each programmable input's direction from data bits 7:0, selecting sourcing or sinking.
// - metallic command selects 16 mA or 2.0 mA drive level.
// - ground-switch input pull-up follows the tri-state command.
// - ground-switch comparator keeps reporting while tri-stated.
// - comparator change while source enabled raises interrupt.
// - configuration commands taken and applied in normal mode.
`timescale 1ns/1ps
`include "sic_params.svh"
module sic_ctrl (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // serial link pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  // comparator results, one when the pin reads low (closed)
  input wire logic [21:0] comp_in,
  // drive, mux and status
  output sic_pkg::sic_drive_t drive_out,
  output sic_pkg::sic_mux_t mux_out,
  output logic [21:0] wetting_timer_en_out,
  output logic normal_mode_out,
  output logic int_n_out
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] sync1_q, sync1_d;
  logic [2:0] sync2_q, sync2_d;
  logic [21:0] cmp1_q, cmp2_q, cmp_last_q;
  // two stages for every asynchronous pin
  always_comb begin
    sync1_d = {sclk_in, cs_n_in, mosi_in};
    sync2_d = sync1_q;
  end
  always_ff @(posedge core_clk_in) begin
    sync1_q <= sync1_d;
    sync2_q <= sync2_d;
    cmp1_q <= comp_in;
    cmp2_q <= cmp1_q;
  end
  logic sclk_s, cs_n_s, mosi_s;
  assign {sclk_s, cs_n_s, mosi_s} = sync2_q;

  // ************************************************************
  // serial shifter and frame end detection
  // ************************************************************
  logic sclk_prev_q, sclk_prev_d, cs_prev_q, cs_prev_d;
  logic [23:0] rx_q, rx_d, tx_q, tx_d;
  logic miso_q, miso_d;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign cs_fall = ~cs_n_s & cs_prev_q;
  assign cs_rise = cs_n_s & ~cs_prev_q;
  logic [21:0] status_word;
  logic [1:0] ana_cur_bits;
  // mode 0: sample on rising sclk, shift out on falling
  always_comb begin
    sclk_prev_d = sclk_s;
    cs_prev_d = cs_n_s;
    rx_d = rx_q;
    tx_d = tx_q;
    miso_d = miso_q;
    if (cs_fall) begin
      // frame bit 23 must stand before the first rising clock, so queue bit 22 next
      miso_d = 1'b0;
      tx_d = {1'b0, status_word, 1'b0};
    end else if (!cs_n_s && sclk_rise) begin
      rx_d = {rx_q[22:0], mosi_s};
    end else if (!cs_n_s && sclk_fall) begin
      miso_d = tx_q[23];
      tx_d = {tx_q[22:0], 1'b0};
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      rx_q <= 24'h000000;
      tx_q <= 24'h000000;
      miso_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      cs_prev_q <= cs_prev_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      miso_q <= miso_d;
    end
  end

  // ************************************************************
  // configuration state, applied at chip select rise
  // ************************************************************
  logic [21:0] tri_q, tri_d, lvl_q, lvl_d, wet_q, wet_d;
  logic [7:0] dir_q, dir_d;
  sic_pkg::sic_mux_t mux_q, mux_d;
  logic [7:0] cmd;
  assign cmd = rx_q[`SIC_CMD_HI:`SIC_CMD_LO];
  assign ana_cur_bits = rx_q[`SIC_ANA_CUR_HI:`SIC_ANA_CUR_LO];
  // programmable inputs sit in data bits 7:0, ground inputs in bits 13:0
  always_comb begin
    tri_d = tri_q;
    lvl_d = lvl_q;
    wet_d = wet_q;
    dir_d = dir_q;
    mux_d = mux_q;
    if (cs_rise) begin
      unique case (cmd)
        `SIC_CMD_SETTINGS: dir_d = rx_q[7:0];
        `SIC_CMD_METALLIC: lvl_d = {rx_q[13:0], rx_q[7:0]} & 22'h3fffff;
        `SIC_CMD_WETTING: wet_d = {rx_q[13:0], rx_q[7:0]};
        `SIC_CMD_TRISTATE: tri_d[7:0] = rx_q[7:0];
        `SIC_CMD_TRISTATE_SG: tri_d[21:8] = rx_q[13:0];
        `SIC_CMD_ANALOG: begin
          // codes above 21 deselect the mux
          if (rx_q[`SIC_ANA_CH_HI:0] < 5'h16) begin
            mux_d.valid = 1'b1;
            mux_d.channel = rx_q[`SIC_ANA_CH_HI:0];
          end else begin
            mux_d.valid = 1'b0;
            mux_d.channel = `SIC_ANA_NONE;
          end
          unique case (ana_cur_bits)
            2'b01: mux_d.current = sic_pkg::SIC_ANA_LO;
            2'b10: mux_d.current = sic_pkg::SIC_ANA_HI;
            default: mux_d.current = sic_pkg::SIC_ANA_HIZ;
          endcase
        end
        default: mux_d = mux_q;
      endcase
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tri_q <= `SIC_RST_TRI;
      lvl_q <= `SIC_RST_HI_LVL;
      wet_q <= `SIC_RST_WET;
      dir_q <= `SIC_RST_DIR;
      mux_q <= '{valid: 1'b0, channel: `SIC_ANA_NONE, current: sic_pkg::SIC_ANA_HIZ};
    end else begin
      tri_q <= tri_d;
      lvl_q <= lvl_d;
      wet_q <= wet_d;
      dir_q <= dir_d;
      mux_q <= mux_d;
    end
  end

  // ************************************************************
  // current source steering, status and interrupt
  // ************************************************************
  sic_pkg::sic_drive_t drv_q, drv_d;
  logic [21:0] src_on, sel_mask;
  logic int_n_q, int_n_d;
  // dir=1 battery switch sinks, dir=0 ground switch sources
  always_comb begin
    drv_d.pullup_en = ~tri_q;
    drv_d.pulldown_en = 22'h000000;
    drv_d.pullup_en[7:0] = ~tri_q[7:0] & ~dir_q;
    drv_d.pulldown_en[7:0] = ~tri_q[7:0] & dir_q;
    drv_d.high_level = lvl_q;
    sel_mask = 22'h000000;
    if (mux_q.valid) begin
      sel_mask[mux_q.channel] = 1'b1;
      // analog input drives only its chosen pull-up
      drv_d.pullup_en[mux_q.channel] = (mux_q.current != sic_pkg::SIC_ANA_HIZ);
      drv_d.pulldown_en[mux_q.channel] = 1'b0;
      drv_d.high_level[mux_q.channel] = (mux_q.current == sic_pkg::SIC_ANA_HI);
    end
    src_on = drv_q.pullup_en | drv_q.pulldown_en;
    // comparators stay live while tri-stated
    status_word = cmp2_q & ~sel_mask;
    int_n_d = int_n_q;
    // a change in the same cycle as a frame opening wins, so no event is lost
    if (|((cmp2_q ^ cmp_last_q) & src_on)) begin
      int_n_d = 1'b0;
    end else if (cs_fall) begin
      int_n_d = 1'b1; // cleared when host opens a frame
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      drv_q <= '0;
      int_n_q <= 1'b1;
      // follow the pins through reset so release brings no false change
      cmp_last_q <= cmp2_q;
    end else begin
      drv_q <= drv_d;
      int_n_q <= int_n_d;
      cmp_last_q <= cmp2_q;
    end
  end

  // only normal mode exists in this block; a flop keeps the output registered
  logic normal_q;
  always_ff @(posedge core_clk_in) begin
    normal_q <= 1'b1;
  end

  // outputs straight from flip-flops
  assign drive_out = drv_q;
  assign mux_out = mux_q;
  assign wetting_timer_en_out = wet_q;
  assign normal_mode_out = normal_q;
  assign miso_out = miso_q;
  assign int_n_out = int_n_q;
endmodule : sic_ctrl

// ### tb/sic_host_model.sv
// Purpose: host side of the serial link for the switch input block
// Assumes: mode 0 framing, 24 bits, msb first, 80 ns serial clock
// Notes: serial clock idles low between frames
`timescale 1ns/1ps
module sic_host_model (
  // serial link
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // one whole frame; reply taken on each rising serial clock
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    cs_n_out = 1'b0;
    #80;
    for (int i = 23; i >= 0; i--) begin
      mosi_out = tx[i];
      #40 sclk_out = 1'b1;
      rx[i] = miso_in;
      #40 sclk_out = 1'b0;
    end
    #40 cs_n_out = 1'b1;
    mosi_out = ~mosi_out; // stale data never looks valid
    #200;
  endtask : xfer
endmodule : sic_host_model

// ### tb/sic_ctrl_checker.sv
// Purpose: port level checks for the switch input block
// Assumes: single core clock domain
// Notes: helper counters stand in for long waits
`timescale 1ns/1ps
module sic_ctrl_checker (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // watched pins
  input wire logic cs_n_in,
  input wire logic [21:0] comp_in,
  input wire sic_pkg::sic_drive_t drive_out,
  input wire sic_pkg::sic_mux_t mux_out,
  input wire logic normal_mode_out,
  input wire logic int_n_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic [3:0] hi_q, hi_d, cc_q, cc_d;
  logic [21:0] cp_q;
  // cycles since chip select went high or reset ended, and since a comparator moved
  // reset release counts as a frame end: the drive word settles one cycle after it
  always_comb begin
    hi_d = !cs_n_in ? 4'h0 : (hi_q == 4'hf) ? hi_q : hi_q + 4'h1;
    cc_d = (comp_in != cp_q) ? 4'h0 : (cc_q == 4'hf) ? cc_q : cc_q + 4'h1;
  end
  always_ff @(posedge core_clk_in) begin
    hi_q <= rst_in ? 4'h0 : hi_d;
    cc_q <= rst_in ? 4'hf : cc_d;
    cp_q <= comp_in;
  end
  sequence s_after_cs;
    hi_q inside {[4'h1:4'hb]};
  endsequence
  property p_mux_win; $changed(mux_out) |-> s_after_cs; endproperty
  a_mux_win: assert property (p_mux_win) else $error("mux moved outside frame end");
  property p_drv_win; $changed(drive_out) |-> s_after_cs; endproperty
  a_drv_win: assert property (p_drv_win) else $error("drive moved outside frame end");
  property p_chan; mux_out.valid |-> mux_out.channel < 5'h16; endproperty
  a_chan: assert property (p_chan) else $error("bad mux channel");
  property p_cur; mux_out.valid |-> mux_out.current != 2'b11; endproperty
  a_cur: assert property (p_cur) else $error("bad analog current");
  property p_fight; (drive_out.pullup_en & drive_out.pulldown_en) == 22'h0; endproperty
  a_fight: assert property (p_fight) else $error("source and sink both on");
  property p_sg; drive_out.pulldown_en[21:8] == 14'h0; endproperty
  a_sg: assert property (p_sg) else $error("ground input sinking");
  property p_norm; normal_mode_out; endproperty
  a_norm: assert property (p_norm) else $error("left normal mode");
  property p_int; $fell(int_n_out) |-> cc_q <= 4'h8; endproperty
  a_int: assert property (p_int) else $error("interrupt without change");
  // a pin change on a driven input must pull the interrupt low within a few cycles
  property p_int_set;
    |((comp_in ^ cp_q) & (drive_out.pullup_en | drive_out.pulldown_en))
      |-> ##[1:4] !int_n_out;
  endproperty
  a_int_set: assert property (p_int_set) else $error("no interrupt on input change");
  property p_rst; $past(rst_in) |-> drive_out == '0 && int_n_out && !mux_out.valid; endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
endmodule : sic_ctrl_checker
bind sic_ctrl sic_ctrl_checker chk_u (.core_clk_in, .rst_in, .cs_n_in, .comp_in, .drive_out,
  .mux_out, .normal_mode_out, .int_n_out);

// ### tb/tb_sic_ctrl.sv
// Purpose: command level test of the switch input block
// Assumes: host model drives the serial link
// Notes: waits after each frame cover the sync delay
`timescale 1ns/1ps
`include "sic_params.svh"
module tb_sic_ctrl;
  logic clk = 1'b0, rst = 1'b1, sclk, cs_n, mosi, miso, nm, int_n;
  logic [21:0] comp = 22'h3fffff, wet;
  logic [23:0] rx;
  sic_pkg::sic_drive_t drv;
  sic_pkg::sic_mux_t mux;
  int n_mismatch = 0, total_checks = 0;
  always #4 clk = ~clk;
  sic_host_model host_u (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
  sic_ctrl dut_u (.core_clk_in(clk), .rst_in(rst), .sclk_in(sclk), .cs_n_in(cs_n),
    .mosi_in(mosi), .miso_out(miso), .comp_in(comp), .drive_out(drv), .mux_out(mux),
    .wetting_timer_en_out(wet), .normal_mode_out(nm), .int_n_out(int_n));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op, input logic [15:0] dat);
    host_u.xfer({op, dat}, rx);
  endtask : cmd
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // watchdog, well past the expected fifteen frames
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(drv.pullup_en | drv.pulldown_en, 24'h0);
    chk(int_n, 24'h1);
    chk(nm, 24'h1);
    cmd(`SIC_CMD_WETTING, 16'h0000);
    chk(wet, 24'h0);
    cmd(`SIC_CMD_METALLIC, 16'h0000);
    chk(drv.high_level, 24'h0);
    cmd(`SIC_CMD_METALLIC, 16'h3fff);
    chk(drv.high_level, 24'h3fffff);
    cmd(`SIC_CMD_SETTINGS, 16'h00ff);
    cmd(`SIC_CMD_TRISTATE, 16'h0000);
    chk({drv.pulldown_en[7:0], drv.pullup_en[7:0]}, 24'hff00);
    // battery, ground, battery again
    for (int k = 0; k < 3; k++) begin
      cmd(`SIC_CMD_SETTINGS, (k == 1) ? 16'h0000 : 16'h00ff);
      chk({drv.pulldown_en[7:0], drv.pullup_en[7:0]}, (k == 1) ? 24'h00ff : 24'hff00);
    end
    cmd(`SIC_CMD_TRISTATE_SG, 16'h0000);
    chk(drv.pullup_en[21:8], 24'h3fff);
    cmd(`SIC_CMD_TRISTATE_SG, 16'h3fff);
    chk(drv.pullup_en[21:8], 24'h0);
    @(posedge clk);
    #1 comp[0] = 1'b0;
    repeat (8) @(posedge clk);
    chk(int_n, 24'h0);
    for (int c = 0; c < 3; c++) begin
      cmd(`SIC_CMD_ANALOG, {9'h0, c[1:0], 5'h15});
      chk(mux, {1'b1, 5'h15, c[1:0]});
      chk({drv.pullup_en[21], drv.high_level[21]}, {c != 0, c == 2});
    end
    cmd(`SIC_CMD_STATUS, 16'h0000);
    chk(rx, 24'h1ffffe);
    chk(int_n, 24'h1);
    chk(mux, {1'b1, 5'h15, 2'b10});
    cmd(`SIC_CMD_ANALOG, 16'h0016);
    chk(mux.valid, 24'h0);
    // second reset with live settings: every source must drop back to tri-state
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(drv.pullup_en | drv.pulldown_en, 24'h0);
    chk(mux, {1'b0, `SIC_ANA_NONE, 2'b00});
    final_report();
  end
endmodule : tb_sic_ctrl
